// >>> hw/csxs_exec.sv
/*
  execution datapath for standby entry, the three subtractions, nibble
  exchange, direction load and the two exclusive-or operations, with the
  carry, digit-carry, zero, timeout and power-down flags and a watchdog.
  assumes a single ahb-lite master on the core clock; the far register
  file supplies the file operand through a register and takes results
  from the file write port.
*/
// Decided for this implementation: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module csxs_exec (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // core side
  output csxs_pkg::csxs_fwr_t file_wr,
  output csxs_pkg::csxs_dir_t port_dir,
  output logic standby
);

  csxs_pkg::csxs_state_t s_q;
  csxs_pkg::csxs_state_t s_d;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  logic addr_take;
  logic wr_now;
  logic ctrl_wr;
  logic [2:0] op;
  logic dest;
  logic [7:0] opnd;

  // only whole-word transfers are taken; others complete without effect
  assign addr_take = hsel & htrans[1] & hready & (hsize == 3'h2);
  assign wr_now = s_q.a_wr & hready;
  // standby stops the oscillator, so launches are dropped until woken
  assign ctrl_wr = wr_now & (s_q.a_addr == csxs_pkg::ADDR_CTRL) & (s_q.mode == csxs_pkg::MODE_RUN);
  assign op = hwdata[csxs_pkg::CTRL_OP_MSB:csxs_pkg::CTRL_OP_LSB];
  assign dest = hwdata[csxs_pkg::CTRL_DEST_BIT];
  assign opnd = hwdata[csxs_pkg::CTRL_OPND_MSB:csxs_pkg::CTRL_OPND_LSB];

  // ----------------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------------
  logic [7:0] minuend;
  logic borrow_in;
  logic [8:0] diff9;
  logic [4:0] diff5;
  logic [7:0] xor_res;
  logic [7:0] swap_res;

  // one subtractor serves all three forms; the borrow is the inverted carry
  // borrow out of bit 8 or bit 4 is kept inverted, so 1 in a flag means no borrow
  assign minuend = (op == csxs_pkg::OP_LITERAL_MINUS_ACC) ? opnd : s_q.file_in;
  assign borrow_in = (op == csxs_pkg::OP_REG_MINUS_ACC_BORROW) ? ~s_q.c : 1'b0;
  assign diff9 = {1'b0, minuend} - {1'b0, s_q.acc} - {8'h00, borrow_in};
  assign diff5 = {1'b0, minuend[3:0]} - {1'b0, s_q.acc[3:0]} - {4'h0, borrow_in};
  assign xor_res = s_q.acc ^ ((op == csxs_pkg::OP_LITERAL_XOR) ? opnd : s_q.file_in);
  assign swap_res = {s_q.file_in[3:0], s_q.file_in[7:4]};

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // read data is built one cycle after the address phase, so a write in the
  // preceding data phase is already visible; this costs one wait state
  always_comb begin
    s_d = s_q;
    s_d.fwr.en = 1'b0;
    // read data phase, then address phase
    if (s_q.a_rd) begin
      s_d.a_rd = 1'b0;
      s_d.hready = 1'b1;
      s_d.hrdata = 32'h0000_0000;
      unique case (s_q.a_addr)
        csxs_pkg::ADDR_CTRL: s_d.hrdata = 32'h0000_0000;
        csxs_pkg::ADDR_ACC: s_d.hrdata[7:0] = s_q.acc;
        csxs_pkg::ADDR_STATUS: begin
          s_d.hrdata[csxs_pkg::ST_C_BIT] = s_q.c;
          s_d.hrdata[csxs_pkg::ST_DC_BIT] = s_q.dc;
          s_d.hrdata[csxs_pkg::ST_Z_BIT] = s_q.z;
          s_d.hrdata[csxs_pkg::ST_PD_BIT] = s_q.pd_n;
          s_d.hrdata[csxs_pkg::ST_TO_BIT] = s_q.to_n;
          s_d.hrdata[csxs_pkg::ST_STANDBY_BIT] = (s_q.mode == csxs_pkg::MODE_STANDBY);
        end
        csxs_pkg::ADDR_FILE_IN: s_d.hrdata[7:0] = s_q.file_in;
        csxs_pkg::ADDR_FILE_OUT: begin
          s_d.hrdata[7:0] = s_q.fwr.data;
          s_d.hrdata[csxs_pkg::FOUT_ADDR_LSB +: 7] = s_q.fwr.addr;
        end
        csxs_pkg::ADDR_DIRECTION_LOAD_OP: begin
          s_d.hrdata[7:0] = s_q.dir.dir_a;
          s_d.hrdata[csxs_pkg::DIRECTION_LOAD_OP_B_LSB +: 8] = s_q.dir.dir_b;
          s_d.hrdata[csxs_pkg::DIRECTION_LOAD_OP_C_LSB +: 8] = s_q.dir.dir_c;
        end
        csxs_pkg::ADDR_WDOG: begin
          s_d.hrdata[7:0] = s_q.wdog;
          s_d.hrdata[csxs_pkg::WDOG_PRESC_LSB +: 8] = s_q.presc;
        end
        default: s_d.hrdata = 32'h0000_0000; // unmapped reads zero, okay
      endcase
    end
    if (hready) begin
      s_d.a_wr = addr_take & hwrite;
      s_d.a_addr = haddr[7:0];
      if (addr_take & ~hwrite) begin
        s_d.a_rd = 1'b1;
        s_d.hready = 1'b0;
      end
    end
    // watchdog runs only while the oscillator runs
    if (s_q.mode == csxs_pkg::MODE_RUN) begin
      s_d.presc = s_q.presc + 8'h01;
      if (s_q.presc == csxs_pkg::PRESC_WRAP) begin
        s_d.wdog = s_q.wdog + 8'h01;
      end
    end
    // plain register writes in the data phase
    if (wr_now) begin
      unique case (s_q.a_addr)
        csxs_pkg::ADDR_ACC: s_d.acc = hwdata[7:0];
        csxs_pkg::ADDR_FILE_IN: s_d.file_in = hwdata[7:0];
        csxs_pkg::ADDR_STATUS: begin
          s_d.c = hwdata[csxs_pkg::ST_C_BIT];
          s_d.dc = hwdata[csxs_pkg::ST_DC_BIT];
          s_d.z = hwdata[csxs_pkg::ST_Z_BIT];
          if (hwdata[csxs_pkg::ST_WAKE_BIT]) begin
            s_d.mode = csxs_pkg::MODE_RUN;
          end
        end
        default: s_d.fwr.en = 1'b0;
      endcase
    end
    // operation launch
    if (ctrl_wr) begin
      unique case (op)
        csxs_pkg::OP_STANDBY: begin
          s_d.wdog = csxs_pkg::WDOG_CLEAR;
          s_d.presc = csxs_pkg::PRESC_CLEAR;
          s_d.to_n = 1'b1;
          s_d.pd_n = 1'b0;
          s_d.mode = csxs_pkg::MODE_STANDBY;
        end
        csxs_pkg::OP_LITERAL_MINUS_ACC: begin
          s_d.acc = diff9[7:0];
          s_d.c = ~diff9[8];
          s_d.dc = ~diff5[4];
          s_d.z = (diff9[7:0] == 8'h00);
        end
        csxs_pkg::OP_REG_MINUS_ACC, csxs_pkg::OP_REG_MINUS_ACC_BORROW: begin
          if (dest == csxs_pkg::DEST_ACC) begin
            s_d.acc = diff9[7:0];
          end else begin
            s_d.fwr = '{en: 1'b1, addr: opnd[6:0], data: diff9[7:0]};
          end
          s_d.c = ~diff9[8];
          s_d.dc = ~diff5[4];
          s_d.z = (diff9[7:0] == 8'h00);
        end
        csxs_pkg::OP_NIBBLE_EXCHANGE: begin
          // flags untouched
          if (dest == csxs_pkg::DEST_ACC) begin
            s_d.acc = swap_res;
          end else begin
            s_d.fwr = '{en: 1'b1, addr: opnd[6:0], data: swap_res};
          end
        end
        csxs_pkg::OP_DIRECTION_LOAD: begin
          // operands other than 5..7 select nothing and are dropped
          if (opnd == csxs_pkg::DIR_SEL_A) begin
            s_d.dir.dir_a = s_q.acc;
          end
          if (opnd == csxs_pkg::DIR_SEL_B) begin
            s_d.dir.dir_b = s_q.acc;
          end
          if (opnd == csxs_pkg::DIR_SEL_C) begin
            s_d.dir.dir_c = s_q.acc;
          end
        end
        csxs_pkg::OP_LITERAL_XOR: begin
          s_d.acc = xor_res;
          s_d.z = (xor_res == 8'h00);
        end
        csxs_pkg::OP_REG_XOR: begin
          if (dest == csxs_pkg::DEST_ACC) begin
            s_d.acc = xor_res;
          end else begin
            s_d.fwr = '{en: 1'b1, addr: opnd[6:0], data: xor_res};
          end
          s_d.z = (xor_res == 8'h00);
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= csxs_pkg::STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops, except hresp which is tied to zero
  assign hrdata = s_q.hrdata;
  assign hreadyout = s_q.hready;
  assign hresp = 1'b0;
  assign file_wr = s_q.fwr;
  assign port_dir = s_q.dir;
  assign standby = (s_q.mode == csxs_pkg::MODE_STANDBY);

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // one strobe per launched operation, for the checks below
  logic go_stby;
  logic go_subl;
  logic go_subf;
  logic go_subfb;
  logic go_swap;
  logic go_dir;
  logic go_xorl;
  logic go_xorf;
  assign go_stby = ctrl_wr & (op == csxs_pkg::OP_STANDBY);
  assign go_subl = ctrl_wr & (op == csxs_pkg::OP_LITERAL_MINUS_ACC);
  assign go_subf = ctrl_wr & (op == csxs_pkg::OP_REG_MINUS_ACC);
  assign go_subfb = ctrl_wr & (op == csxs_pkg::OP_REG_MINUS_ACC_BORROW);
  assign go_swap = ctrl_wr & (op == csxs_pkg::OP_NIBBLE_EXCHANGE);
  assign go_dir = ctrl_wr & (op == csxs_pkg::OP_DIRECTION_LOAD);
  assign go_xorl = ctrl_wr & (op == csxs_pkg::OP_LITERAL_XOR);
  assign go_xorf = ctrl_wr & (op == csxs_pkg::OP_REG_XOR);

  // standby entry: watchdog, flags, the halt and the dropped launches
  stby_watchdog_a: assert property (go_stby |=> s_q.wdog == 8'h00 && s_q.presc == 8'h00)
    else $error("standby did not clear the watchdog");
  stby_flags_a: assert property (go_stby |=> s_q.to_n && !s_q.pd_n && $stable(s_q.c)
    && $stable(s_q.dc) && $stable(s_q.z))
    else $error("standby flag update wrong");
  stby_halt_a: assert property (go_stby |=> standby ##1 (standby && $stable(s_q.wdog)))
    else $error("standby did not halt the block");
  stby_only_a: assert property ($rose(standby) |-> $past(go_stby))
    else $error("standby entered without a launch");
  wdog_frozen_a: assert property (standby |=> $stable(s_q.wdog) && $stable(s_q.presc))
    else $error("watchdog ran in standby");
  stby_drop_a: assert property (wr_now && s_q.a_addr == csxs_pkg::ADDR_CTRL && standby |=> !file_wr.en
    && $stable(s_q.acc) && $stable(s_q.z) && $stable(port_dir))
    else $error("launch taken in standby");

  // subtractions: result, routing and the no-borrow flags
  subl_result_a: assert property (go_subl |=> s_q.acc == $past(opnd) - $past(s_q.acc)
    && s_q.c == ($past(s_q.acc) <= $past(opnd)) && s_q.dc == ($past(s_q.acc[3:0]) <= $past(opnd[3:0]))
    && s_q.z == (s_q.acc == 8'h00))
    else $error("literal subtract wrong");
  subf_acc_a: assert property (go_subf && !dest |=> !file_wr.en
    && s_q.acc == $past(s_q.file_in) - $past(s_q.acc) && s_q.z == (s_q.acc == 8'h00)
    && s_q.dc == ($past(s_q.acc[3:0]) <= $past(s_q.file_in[3:0])))
    else $error("register subtract to accumulator wrong");
  subf_dest_a: assert property (go_subf && dest |=> file_wr.en && $stable(s_q.acc)
    && file_wr.data == $past(s_q.file_in) - $past(s_q.acc) && file_wr.addr == $past(opnd[6:0])
    && s_q.c == ($past(s_q.acc) <= $past(s_q.file_in)))
    else $error("register subtract to file wrong");
  subfb_borrow_a: assert property (go_subfb && !dest |=> !file_wr.en
    && {!s_q.c, s_q.acc} == {1'b0, $past(s_q.file_in)} - {1'b0, $past(s_q.acc)} - {8'h00, !$past(s_q.c)})
    else $error("borrow subtract wrong");
  subfb_flags_a: assert property (go_subfb && dest |=> file_wr.en && $stable(s_q.acc)
    && file_wr.data == $past(s_q.file_in) - $past(s_q.acc) - {7'h00, !$past(s_q.c)}
    && s_q.dc == ({1'b0, $past(s_q.acc[3:0])} + {4'h0, !$past(s_q.c)} <= {1'b0, $past(s_q.file_in[3:0])})
    && s_q.c == ({1'b0, $past(s_q.acc)} + {8'h00, !$past(s_q.c)} <= {1'b0, $past(s_q.file_in)})
    && s_q.z == (file_wr.data == 8'h00))
    else $error("borrow subtract flags wrong");

  // flag-free moves and the exclusive-or forms
  swap_flags_a: assert property (go_swap |=> $stable(s_q.c) && $stable(s_q.dc) && $stable(s_q.z)
    && file_wr.en == $past(dest)
    && (file_wr.en ? file_wr.data : s_q.acc) == {$past(s_q.file_in[3:0]), $past(s_q.file_in[7:4])})
    else $error("nibble exchange wrong");
  dir_load_a: assert property (go_dir && opnd == csxs_pkg::DIR_SEL_B |=> port_dir.dir_b == $past(s_q.acc)
    && $stable(port_dir.dir_a) && $stable(port_dir.dir_c) && $stable(s_q.z))
    else $error("direction load wrong");
  dir_first_a: assert property (go_dir && opnd == csxs_pkg::DIR_SEL_A |=> port_dir.dir_a == $past(s_q.acc)
    && $stable(port_dir.dir_b) && $stable(port_dir.dir_c) && $stable(s_q.c))
    else $error("direction load of port a wrong");
  dir_last_a: assert property (go_dir && opnd == csxs_pkg::DIR_SEL_C |=> port_dir.dir_c == $past(s_q.acc)
    && $stable(port_dir.dir_a) && $stable(port_dir.dir_b) && $stable(s_q.dc))
    else $error("direction load of port c wrong");
  dir_none_a: assert property (go_dir && opnd != csxs_pkg::DIR_SEL_A && opnd != csxs_pkg::DIR_SEL_B
    && opnd != csxs_pkg::DIR_SEL_C |=> $stable(port_dir) && $stable(s_q.acc))
    else $error("direction load with other operand had effect");
  xorl_zero_a: assert property (go_xorl |=> s_q.acc == ($past(s_q.acc) ^ $past(opnd))
    && s_q.z == (s_q.acc == 8'h00) && $stable(s_q.c) && $stable(s_q.dc))
    else $error("literal xor wrong");
  xorf_route_a: assert property (go_xorf && dest |=> file_wr.en && $stable(s_q.acc) && $stable(s_q.c)
    && file_wr.data == ($past(s_q.acc) ^ $past(s_q.file_in)) && s_q.z == (file_wr.data == 8'h00))
    else $error("register xor wrong");
  xorf_acc_a: assert property (go_xorf && !dest |=> !file_wr.en && $stable(s_q.dc)
    && s_q.acc == ($past(s_q.acc) ^ $past(s_q.file_in)) && s_q.z == (s_q.acc == 8'h00))
    else $error("register xor to accumulator wrong");

  // bus timing and refused transfers
  read_wait_a: assert property (addr_take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  odd_size_a: assert property (hsel && htrans[1] && hready && hsize != 3'h2 |=> hreadyout && !s_q.a_wr && !s_q.a_rd)
    else $error("non-word transfer was taken");

  // the main scenarios, for coverage
  stby_seen_c: cover property (go_stby ##[1:20] (wr_now && s_q.a_addr == csxs_pkg::ADDR_STATUS));
  subfb_borrow_c: cover property (go_subfb && !s_q.c);
  xor_zero_c: cover property (go_xorl ##1 s_q.z);
  file_back_c: cover property (file_wr.en);
  stby_drop_c: cover property (standby && wr_now && s_q.a_addr == csxs_pkg::ADDR_CTRL);

endmodule

// >>> hw/csxs_pkg.sv
/*
  package for the subtract / swap / xor / standby execution block:
  register offsets, control and status field positions, operation codes,
  reset values and the packed types that carry the block's state.
  assumes a 32-bit ahb-lite slave port, one aligned word per register.
*/
package csxs_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00; // write launches one operation
  localparam logic [7:0] ADDR_ACC = 8'h04; // accumulator
  localparam logic [7:0] ADDR_STATUS = 8'h08; // flags and standby state
  localparam logic [7:0] ADDR_FILE_IN = 8'h0c; // file register operand value
  localparam logic [7:0] ADDR_FILE_OUT = 8'h10; // last file register write-back
  localparam logic [7:0] ADDR_DIRECTION_LOAD_OP = 8'h14; // port direction registers a/b/c
  localparam logic [7:0] ADDR_WDOG = 8'h18; // watchdog counter and prescaler

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_OP_MSB = 2;
  localparam int CTRL_DEST_BIT = 3;
  localparam int CTRL_OPND_LSB = 8;
  localparam int CTRL_OPND_MSB = 15;
  localparam int ST_C_BIT = 0;
  localparam int ST_DC_BIT = 1;
  localparam int ST_Z_BIT = 2;
  localparam int ST_PD_BIT = 3;
  localparam int ST_TO_BIT = 4;
  localparam int ST_STANDBY_BIT = 5;
  localparam int ST_WAKE_BIT = 6;
  localparam int FOUT_ADDR_LSB = 8;
  localparam int FOUT_EN_BIT = 16;
  localparam int DIRECTION_LOAD_OP_B_LSB = 8;
  localparam int DIRECTION_LOAD_OP_C_LSB = 16;
  localparam int WDOG_PRESC_LSB = 8;

  // ----------------------------------------------------------------------
  // operation codes and operand values
  // ----------------------------------------------------------------------
  localparam logic [2:0] OP_STANDBY = 3'h0;
  localparam logic [2:0] OP_LITERAL_MINUS_ACC = 3'h1;
  localparam logic [2:0] OP_REG_MINUS_ACC = 3'h2;
  localparam logic [2:0] OP_REG_MINUS_ACC_BORROW = 3'h3;
  localparam logic [2:0] OP_NIBBLE_EXCHANGE = 3'h4;
  localparam logic [2:0] OP_DIRECTION_LOAD = 3'h5;
  localparam logic [2:0] OP_LITERAL_XOR = 3'h6;
  localparam logic [2:0] OP_REG_XOR = 3'h7;
  localparam logic [7:0] DIR_SEL_A = 8'h05;
  localparam logic [7:0] DIR_SEL_B = 8'h06;
  localparam logic [7:0] DIR_SEL_C = 8'h07;
  localparam logic DEST_ACC = 1'b0;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam logic [7:0] PRESC_CLEAR = 8'h00;
  localparam logic [7:0] PRESC_WRAP = 8'hff;
  localparam logic [7:0] DIRECTION_LOAD_OP_RST = 8'hff; // all pins inputs after reset

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {MODE_RUN, MODE_STANDBY} csxs_mode_t;

  typedef struct packed {
    logic en;
    logic [6:0] addr;
    logic [7:0] data;
  } csxs_fwr_t;

  typedef struct packed {
    logic [7:0] dir_a;
    logic [7:0] dir_b;
    logic [7:0] dir_c;
  } csxs_dir_t;

  typedef struct packed {
    logic a_wr;
    logic a_rd;
    logic [7:0] a_addr;
    logic hready;
    logic [31:0] hrdata;
    logic [7:0] acc;
    logic c;
    logic dc;
    logic z;
    logic to_n;
    logic pd_n;
    csxs_mode_t mode;
    logic [7:0] file_in;
    csxs_fwr_t fwr;
    csxs_dir_t dir;
    logic [7:0] wdog;
    logic [7:0] presc;
  } csxs_state_t;

  localparam csxs_state_t STATE_RST = '{a_wr: 1'b0, a_rd: 1'b0, a_addr: 8'h00, hready: 1'b1,
    hrdata: 32'h0000_0000, acc: 8'h00, c: 1'b0, dc: 1'b0, z: 1'b0, to_n: 1'b1, pd_n: 1'b1,
    mode: MODE_RUN, file_in: 8'h00, fwr: '{en: 1'b0, addr: 7'h00, data: 8'h00},
    dir: '{dir_a: DIRECTION_LOAD_OP_RST, dir_b: DIRECTION_LOAD_OP_RST, dir_c: DIRECTION_LOAD_OP_RST}, wdog: 8'h00, presc: 8'h00};

endpackage

// >>> verif/csxs_core_model.sv
/*
  core-side model: the register file that takes result write-backs.
  assumes file_wr.en is a one-cycle pulse on the core clock.
*/
`timescale 1ns/1ps

module csxs_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // write-back port of the block
  input csxs_pkg::csxs_fwr_t file_wr
);
  logic [7:0] mem [128];
  int wr_count;

  // count every cycle with en high, so a stretched pulse shows as two writes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_count <= 0;
    end else if (file_wr.en === 1'b1) begin
      mem[file_wr.addr] <= file_wr.data;
      wr_count <= wr_count + 1;
    end
  end
endmodule

// >>> verif/cpu_subtract_swap_xor_sleep_ops_tb.sv
/*
  self-checking bench for the execution block: table of operations, then
  direction load, standby entry and wake, unmapped access and a second reset.
  assumes one ahb-lite master (this bench) and the core model on file_wr.
*/
`timescale 1ns/1ps

module cpu_subtract_swap_xor_sleep_ops_tb;
  typedef struct packed {
    logic [2:0] op;
    logic dest;
    logic [7:0] opnd;
    logic [7:0] acc;
    logic [7:0] fin;
    logic [2:0] st;
    logic [7:0] eacc;
    logic [2:0] est;
    logic fen;
    logic [7:0] fdat;
  } csxs_row_t;

  logic clk, rst_b, hsel, hwrite, hreadyout, hresp, standby;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  csxs_pkg::csxs_fwr_t file_wr;
  csxs_pkg::csxs_dir_t port_dir;
  int mismatches, n_checks, c0, i;
  csxs_row_t r;
  // op dest opnd acc fin st(z,dc,c) -> acc st write-back data
  csxs_row_t rows [13] = '{
    '{3'h1, 1'b0, 8'h05, 8'h03, 8'h00, 3'h0, 8'h02, 3'h3, 1'b0, 8'h00},
    '{3'h1, 1'b0, 8'h10, 8'h21, 8'h00, 3'h7, 8'hef, 3'h0, 1'b0, 8'h00},
    '{3'h1, 1'b0, 8'h42, 8'h42, 8'h00, 3'h0, 8'h00, 3'h7, 1'b0, 8'h00},
    '{3'h2, 1'b0, 8'h00, 8'h0f, 8'h30, 3'h0, 8'h21, 3'h1, 1'b0, 8'h00},
    '{3'h2, 1'b1, 8'h7f, 8'h01, 8'h80, 3'h0, 8'h01, 3'h1, 1'b1, 8'h7f},
    '{3'h3, 1'b0, 8'h00, 8'h0f, 8'h10, 3'h0, 8'h00, 3'h5, 1'b0, 8'h00},
    '{3'h3, 1'b1, 8'h00, 8'h06, 8'h05, 3'h1, 8'h06, 3'h0, 1'b1, 8'hff},
    '{3'h4, 1'b0, 8'h00, 8'h00, 8'ha5, 3'h5, 8'h5a, 3'h5, 1'b0, 8'h00},
    '{3'h4, 1'b1, 8'h12, 8'h77, 8'h3c, 3'h2, 8'h77, 3'h2, 1'b1, 8'hc3},
    '{3'h6, 1'b0, 8'hff, 8'hff, 8'h00, 3'h3, 8'h00, 3'h7, 1'b0, 8'h00},
    '{3'h6, 1'b0, 8'h0f, 8'hf0, 8'h00, 3'h4, 8'hff, 3'h0, 1'b0, 8'h00},
    '{3'h7, 1'b0, 8'h00, 8'haa, 8'h55, 3'h7, 8'hff, 3'h3, 1'b0, 8'h00},
    '{3'h7, 1'b1, 8'h40, 8'h33, 8'h33, 3'h0, 8'h33, 3'h4, 1'b1, 8'h00}
  };

  csxs_exec u_dut (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .file_wr(file_wr), .port_dir(port_dir), .standby(standby)
  );

  csxs_core_model u_model (.clk(clk), .rst_b(rst_b), .file_wr(file_wr));

  // ----------------------------------------------------------------------
  // clock, report and bus tasks
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // wait for hready sampled high at a rising edge; only the watchdog ends a hang
  task wait_rdy;
    while (hreadyout !== 1'b1) begin
      @(posedge clk);
    end
  endtask

  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    wait_rdy;
    rd = hrdata;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    xfer(1'b1, a, d, t);
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] t;
    xfer(1'b0, a, 32'h0, t);
    chk(t, exp);
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mismatches = 0;
    n_checks = 0;
    repeat (20) @(posedge clk);
    chk({8'h0, port_dir}, 32'h00ffffff);
    chk({15'h0, standby, file_wr}, 32'h0);
    rst_b <= 1'b1;
    rdchk(csxs_pkg::ADDR_STATUS, 32'h18);
    // table of operations, operands and flags set up through the bus
    for (i = 0; i < 13; i++) begin
      r = rows[i];
      wr(csxs_pkg::ADDR_ACC, {24'h0, r.acc});
      wr(csxs_pkg::ADDR_FILE_IN, {24'h0, r.fin});
      wr(csxs_pkg::ADDR_STATUS, {29'h0, r.st});
      c0 = u_model.wr_count;
      wr(csxs_pkg::ADDR_CTRL, {16'h0, r.opnd, 4'h0, r.dest, r.op});
      rdchk(csxs_pkg::ADDR_ACC, {24'h0, r.eacc});
      rdchk(csxs_pkg::ADDR_STATUS, 32'h18 | {29'h0, r.est});
      chk(u_model.wr_count - c0, {31'h0, r.fen});
      if (r.fen) begin
        chk({24'h0, u_model.mem[r.opnd[6:0]]}, {24'h0, r.fdat});
        rdchk(csxs_pkg::ADDR_FILE_OUT, {17'h0, r.opnd[6:0], r.fdat});
      end
    end
    // direction load for each port, then an operand outside 5..7
    wr(csxs_pkg::ADDR_STATUS, 32'h5);
    for (i = 0; i < 4; i++) begin
      wr(csxs_pkg::ADDR_ACC, 32'h12 + 32'h22 * i);
      wr(csxs_pkg::ADDR_CTRL, {16'h0, 8'h05 + 8'(i), 8'h05});
    end
    chk({8'h0, port_dir}, 32'h00123456);
    rdchk(csxs_pkg::ADDR_DIRECTION_LOAD_OP, 32'h00563412);
    rdchk(csxs_pkg::ADDR_STATUS, 32'h1d);
    // standby after the watchdog has run a while; control writes then dropped
    wr(csxs_pkg::ADDR_STATUS, 32'h2);
    wr(csxs_pkg::ADDR_ACC, 32'h3c);
    repeat (300) @(posedge clk);
    wr(csxs_pkg::ADDR_CTRL, 32'h0);
    @(negedge clk);
    chk({31'h0, standby}, 32'h1);
    rdchk(csxs_pkg::ADDR_STATUS, 32'h32);
    rdchk(csxs_pkg::ADDR_WDOG, 32'h0);
    wr(csxs_pkg::ADDR_CTRL, 32'hff06);
    rdchk(csxs_pkg::ADDR_ACC, 32'h3c);
    wr(csxs_pkg::ADDR_STATUS, 32'h42);
    @(negedge clk);
    chk({31'h0, standby}, 32'h0);
    rdchk(csxs_pkg::ADDR_STATUS, 32'h12);
    // unmapped place reads zero and ignores writes
    wr(8'h1c, 32'h5a);
    rdchk(8'h1c, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    // a byte-sized write completes without touching the accumulator
    hsize <= 3'h0;
    wr(csxs_pkg::ADDR_ACC, 32'h99);
    hsize <= 3'h2;
    rdchk(csxs_pkg::ADDR_ACC, 32'h3c);
    // second reset in mid-run brings the power-down flag and ports back
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    chk({8'h0, port_dir}, 32'h00ffffff);
    rdchk(csxs_pkg::ADDR_STATUS, 32'h18);
    rdchk(csxs_pkg::ADDR_ACC, 32'h0);
    final_report;
  end

  // watchdog: the sequence needs about 700 cycles, so 20,000 means a hang
  initial begin
    #(50 * 20000);
    mismatches = mismatches + 1;
    final_report;
  end
endmodule
